// file: rtl/iepc_ctrl.sv
/*
 Interrupt enable, Port1 wake mask and four-level priority selection with nesting.
 Assumes flags arrive on core_clk, cleared by their owners; cpu pulses svcTake and svcReturn.
*/
// Functional notes
// - Pending requests reach the CPU only when global and per-source enables permit.
// - New request serviced only if no equal or higher level is in service.
// - Higher level preempts lower; lower resumes after the higher returns.
// - Port1 wake mask bit n enables wake and interrupt for pin n.
// - Pin 2 enable grants interrupt and Stop wake, wake ignoring global enable.
// - Port1 change enable gates only its interrupt, never Port1 Stop wake.
// - Second enable register bits 5..0: uart2, spi, adc, pin2, port1, timer3.
// - Priority is two bits, high and low; 3 highest, 0 lowest.
// - First priority pair covers timer2, uart1, timer1, pin1, timer0, pin0.
// - Second priority pair covers uart2, spi, adc, pin2, port1, timer3.
// - Flags set regardless of enables; enables gate only service and wake.
// - Idle wake or service needs both source enable and global enable.
// - Port1 pin enters interrupt only with global, change enable and mask bit.
`timescale 1ns/1ns
`include "iepc_defines.svh"
module iepc_ctrl (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             resetn,
	// Register access
	input  wire logic [7:0]       regAddr,
	input  wire logic             regWr,
	input  wire logic [7:0]       regWdata,
	output logic      [7:0]       regRdata,
	// Sources, index in vector order
	input  wire iepc_pkg::iepc_vec_t srcFlag,
	input  wire logic [7:0]       port1Change,
	input  wire logic [2:0]       pinWakeLevel,
	// CPU handshake
	output logic                  irqReq,
	output iepc_pkg::iepc_src_t   irqSrc,
	input  wire logic             svcTake,
	input  wire logic             svcReturn,
	// Wake outputs
	output logic                  idleWake,
	output logic                  stopWake
);
	import iepc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] p1Wake_r, mainEn_r, extraEn_r, mainPl_r, mainPh_r, extraPl_r, extraPh_r;
	logic [7:0] p1Wake_nxt, mainEn_nxt, extraEn_nxt, mainPl_nxt, mainPh_nxt, extraPl_nxt, extraPh_nxt;
	logic [3:0] active_r, active_nxt;
	logic [7:0] rd_nxt, rd_r;

	always_comb begin
		p1Wake_nxt  = p1Wake_r;
		mainEn_nxt  = mainEn_r;
		extraEn_nxt = extraEn_r;
		mainPl_nxt  = mainPl_r;
		mainPh_nxt  = mainPh_r;
		extraPl_nxt = extraPl_r;
		extraPh_nxt = extraPh_r;
		if (regWr) begin
			unique case (regAddr)
				`IEPC_OFS_P1WAKE:  p1Wake_nxt  = regWdata;
				`IEPC_OFS_MAINEN:  mainEn_nxt  = regWdata & `IEPC_MASK_MAINEN;
				`IEPC_OFS_EXTRAEN: extraEn_nxt = regWdata & `IEPC_MASK_SRC;
				`IEPC_OFS_MAINPL:  mainPl_nxt  = regWdata & `IEPC_MASK_SRC;
				`IEPC_OFS_MAINPH:  mainPh_nxt  = regWdata & `IEPC_MASK_SRC;
				`IEPC_OFS_EXTRAPL: extraPl_nxt = regWdata & `IEPC_MASK_SRC;
				`IEPC_OFS_EXTRAPH: extraPh_nxt = regWdata & `IEPC_MASK_SRC;
				default: ;
			endcase
		end
		unique case (regAddr)
			`IEPC_OFS_P1WAKE:  rd_nxt = p1Wake_r;
			`IEPC_OFS_MAINEN:  rd_nxt = mainEn_r;
			`IEPC_OFS_EXTRAEN: rd_nxt = extraEn_r;
			`IEPC_OFS_MAINPL:  rd_nxt = mainPl_r;
			`IEPC_OFS_MAINPH:  rd_nxt = mainPh_r;
			`IEPC_OFS_EXTRAPL: rd_nxt = extraPl_r;
			`IEPC_OFS_EXTRAPH: rd_nxt = extraPh_r;
			default:           rd_nxt = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Per-source enable and level, vector order:
	// 0 pin0,1 tmr0,2 pin1,3 tmr1,4 uart1,5 tmr2,6 tmr3,7 port1,8 pin2,9 adc,10 spi,11 uart2
	logic [11:0] srcEn;
	logic [11:0] srcHi, srcLo;
	logic [11:0] reqOk;
	logic        globalEn;
	logic        port1Hit;

	assign globalEn = mainEn_r[`IEPC_BIT_GLOBAL];
	assign srcEn    = {extraEn_r[5:0], mainEn_r[5:0]};
	assign srcHi    = {extraPh_r[5:0], mainPh_r[5:0]};
	assign srcLo    = {extraPl_r[5:0], mainPl_r[5:0]};
	assign port1Hit = |(port1Change & p1Wake_r);

	genvar gi;
	generate
		for (gi = 0; gi < `IEPC_NSRC; gi++) begin : gReq
			// Flags come in unconditionally; enables act here and on the pin terms of stopWake
			if (gi == 7) begin : gP1
				assign reqOk[gi] = srcFlag[gi] & port1Hit & srcEn[gi] & globalEn;
			end else begin : gOther
				assign reqOk[gi] = srcFlag[gi] & srcEn[gi] & globalEn;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Arbitration: highest level, then lowest vector
	logic        winValid;
	iepc_src_t   winSrc;
	iepc_level_t winLvl;
	logic [2:0]  curLvl;

	always_comb begin
		winValid = 1'b0;
		winSrc   = 4'h0;
		winLvl   = 2'h0;
		for (int l = `IEPC_NLVL - 1; l >= 0; l--) begin
			for (int s = `IEPC_NSRC - 1; s >= 0; s--) begin
				if (!winValid || winLvl == 2'(l)) begin
					if (reqOk[s] && {srcHi[s], srcLo[s]} == 2'(l) && !(winValid && winLvl != 2'(l))) begin
						winSrc = 4'(s);
						winLvl = 2'(l);
					end
				end
			end
			if (|reqOk && !winValid) begin
				for (int s = 0; s < `IEPC_NSRC; s++) begin
					if (reqOk[s] && {srcHi[s], srcLo[s]} == 2'(l)) begin
						winValid = 1'b1;
					end
				end
			end
		end
		// Level one above the highest in service
		curLvl = 3'h0;
		for (int l = 0; l < `IEPC_NLVL; l++) begin
			if (active_r[l]) begin
				curLvl = 3'(l + 1);
			end
		end
	end

	logic grantOk;
	assign grantOk = winValid && ({1'b0, winLvl} >= curLvl);

	////////////////////////////////////////////////////////////////
	// Nesting stack of in-service levels
	always_comb begin
		active_nxt = active_r;
		if (svcReturn) begin
			for (int l = 0; l < `IEPC_NLVL; l++) begin
				if (curLvl == 3'(l + 1)) begin
					active_nxt[l] = 1'b0;
				end
			end
		end
		if (svcTake && grantOk) begin
			active_nxt[winLvl] = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			p1Wake_r  <= `IEPC_RST_REG;
			mainEn_r  <= `IEPC_RST_REG;
			extraEn_r <= `IEPC_RST_REG;
			mainPl_r  <= `IEPC_RST_REG;
			mainPh_r  <= `IEPC_RST_REG;
			extraPl_r <= `IEPC_RST_REG;
			extraPh_r <= `IEPC_RST_REG;
			active_r  <= 4'h0;
			rd_r      <= 8'h00;
		end else begin
			p1Wake_r  <= p1Wake_nxt;
			mainEn_r  <= mainEn_nxt;
			extraEn_r <= extraEn_nxt;
			mainPl_r  <= mainPl_nxt;
			mainPh_r  <= mainPh_nxt;
			extraPl_r <= extraPl_nxt;
			extraPh_r <= extraPh_nxt;
			active_r  <= active_nxt;
			rd_r      <= rd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	logic [2:0] syncA_r, syncB_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			syncA_r <= 3'h0;
			syncB_r <= 3'h0;
		end else begin
			syncA_r <= pinWakeLevel;
			syncB_r <= syncA_r;
		end
	end

	assign regRdata = rd_r;
	assign irqReq   = grantOk;
	assign irqSrc   = winSrc;
	assign idleWake = |reqOk;
	// Stop wake ignores the global enable and the Port1 change enable
	assign stopWake = (syncB_r[0] & mainEn_r[`IEPC_BIT_EXT0]) |
	                  (syncB_r[1] & mainEn_r[`IEPC_BIT_EXT1]) |
	                  (syncB_r[2] & extraEn_r[`IEPC_BIT_EXT2]) |
	                  (|(port1Change & p1Wake_r));

	////////////////////////////////////////////////////////////////
	// Checks
	a_gate_global: assert property (@(posedge core_clk) disable iff (!resetn)
		!globalEn |-> !irqReq && !idleWake) else $error("request without global enable");
	a_block_equal: assert property (@(posedge core_clk) disable iff (!resetn)
		irqReq |-> !(|(active_r >> winLvl))) else $error("equal or higher already active");
	a_nest_push: assert property (@(posedge core_clk) disable iff (!resetn)
		svcTake && irqReq && !svcReturn |=> active_r[$past(winLvl)]) else $error("level not marked");
	a_p1_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		!(|(port1Change & p1Wake_r)) |-> !reqOk[7]) else $error("port1 without mask");
	a_pin2_wake: assert property (@(posedge core_clk) disable iff (!resetn)
		syncB_r[2] && extraEn_r[`IEPC_BIT_EXT2] |-> stopWake) else $error("pin2 wake lost");
	a_p1_wake: assert property (@(posedge core_clk) disable iff (!resetn)
		|(port1Change & p1Wake_r) |-> stopWake) else $error("port1 wake lost");
	a_src_enable: assert property (@(posedge core_clk) disable iff (!resetn)
		irqReq |-> srcEn[irqSrc] && srcFlag[irqSrc]) else $error("disabled source granted");
	a_level_top: assert property (@(posedge core_clk) disable iff (!resetn)
		irqReq && reqOk[0] && {srcHi[0], srcLo[0]} == 2'h3 |-> irqSrc == 4'h0) else $error("order wrong");
	a_reg_mask: assert property (@(posedge core_clk) disable iff (!resetn)
		mainEn_r[6] == 1'b0 && extraEn_r[7:6] == 2'h0) else $error("reserved bit set");
	c_nested: cover property (@(posedge core_clk) disable iff (!resetn) active_r[0] && active_r[3]);
	c_grant: cover property (@(posedge core_clk) disable iff (!resetn) svcTake && irqReq);
	c_stop: cover property (@(posedge core_clk) disable iff (!resetn) stopWake && !globalEn);
endmodule : iepc_ctrl

// file: rtl/iepc_defines.svh
/*
 Register offsets, field positions, reset values and sizes of the interrupt enable and priority block.
 Assumes an 8-bit special-register bus with byte offsets.
*/
`ifndef IEPC_DEFINES_SVH
`define IEPC_DEFINES_SVH
`define IEPC_OFS_P1WAKE    8'h96
`define IEPC_OFS_MAINEN    8'hA8
`define IEPC_OFS_EXTRAEN   8'hA9
`define IEPC_OFS_MAINPL    8'hB8
`define IEPC_OFS_MAINPH    8'hB9
`define IEPC_OFS_EXTRAPL   8'hBA
`define IEPC_OFS_EXTRAPH   8'hBB
`define IEPC_RST_REG       8'h00
`define IEPC_BIT_GLOBAL    7
`define IEPC_BIT_EXT0      0
`define IEPC_BIT_EXT1      2
`define IEPC_BIT_EXT2      2
`define IEPC_BIT_P1CHG     1
`define IEPC_MASK_SRC      8'h3F
`define IEPC_MASK_MAINEN   8'hBF
`define IEPC_NSRC          12
`define IEPC_NLVL          4
`endif

// file: rtl/iepc_pkg.sv
/*
 Types of the interrupt enable and priority block.
 Assumes iepc_defines.svh for the numeric constants.
*/
`include "iepc_defines.svh"
package iepc_pkg;
	typedef logic [1:0] iepc_level_t;
	typedef logic [3:0] iepc_src_t;
	typedef logic [11:0] iepc_vec_t;
endpackage : iepc_pkg

// file: tb/iepc_cpu_model.sv
/*
 Behavioural CPU core that takes granted requests and ends services.
 Assumes the bench enables taking and asks for each return.
*/
`timescale 1ns/1ns
module iepc_cpu_model (
	// Clock
	input  wire logic core_clk,
	// Bench control
	input  wire logic takeEn,
	input  wire logic retReq,
	// Controller side
	input  wire logic irqReq,
	output logic      svcTake   = 1'b0,
	output logic      svcReturn = 1'b0
);
	// One-cycle take pulse, then one cycle low before irqReq can be taken again
	always @(posedge core_clk) begin
		svcTake   <= irqReq & takeEn & ~svcTake;
		svcReturn <= retReq;
	end
endmodule : iepc_cpu_model

// file: tb/iepc_ctrl_tb.sv
/*
 Self-checking bench of the interrupt enable and priority block.
 Assumes the CPU model in iepc_cpu_model.sv.
*/
`timescale 1ns/1ns
module iepc_ctrl_tb;
	import iepc_pkg::*;
	logic            core_clk = 0, resetn = 0, regWr = 0, takeEn = 0, retReq = 0;
	logic            svcTake, svcReturn, irqReq, idleWake, stopWake;
	logic [7:0]      regAddr = 0, regWdata = 0, regRdata, port1Change = 0;
	logic [2:0]      pinWakeLevel = 0;
	iepc_vec_t       srcFlag = 0;
	iepc_src_t       irqSrc;
	int              num_errors = 0, num_checks = 0;
	logic [7:0]      ofs [7] = '{8'h96, 8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hBA, 8'hBB};
	logic [7:0]      msk [7] = '{8'hFF, 8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
	always #2 core_clk = ~core_clk;
	iepc_ctrl iepc_ctrl_inst (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWr(regWr),
		.regWdata(regWdata), .regRdata(regRdata), .srcFlag(srcFlag), .port1Change(port1Change),
		.pinWakeLevel(pinWakeLevel), .irqReq(irqReq), .irqSrc(irqSrc), .svcTake(svcTake),
		.svcReturn(svcReturn), .idleWake(idleWake), .stopWake(stopWake));
	iepc_cpu_model iepc_cpu_model_inst (.core_clk(core_clk), .takeEn(takeEn), .retReq(retReq),
		.irqReq(irqReq), .svcTake(svcTake), .svcReturn(svcReturn));
	////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) begin regWr <= 1'b1; regAddr <= a; regWdata <= d; end
		@(posedge core_clk) regWr <= 1'b0;
	endtask : wr
	task tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk) regAddr <= a;
		tick(1);
		chk("regRdata", {4'h0, e}, {4'h0, regRdata});
	endtask : rd
	task ret;
		@(posedge core_clk) retReq <= 1'b1;
		@(posedge core_clk) retReq <= 1'b0;
		tick(3);
	endtask : ret
	////////////////////////////////////////////////////////////////////////////
	task t_regs;
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i], 8'h00);
			wr(ofs[i], 8'hFF);
			rd(ofs[i], msk[i]);
			wr(ofs[i], 8'h00);
		end
		wr(8'h97, 8'hFF);
		rd(8'h97, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task t_gate;
		@(posedge core_clk) srcFlag <= 12'h001;
		wr(8'hA8, 8'h01);
		tick(1);
		chk("irqReq", 0, irqReq);
		chk("idleWake", 0, idleWake);
		wr(8'hA8, 8'h80);
		tick(1);
		chk("irqReq", 0, irqReq);
		wr(8'hA8, 8'h81);
		tick(1);
		chk("irqReq", 1, irqReq);
		chk("irqSrc", 0, irqSrc);
		chk("idleWake", 1, idleWake);
		$display("test gate done");
	endtask : t_gate
	task t_prio;
		@(posedge core_clk) srcFlag <= 12'h801;
		wr(8'hA9, 8'h20);
		tick(1);
		chk("irqSrc", 0, irqSrc);
		wr(8'hBA, 8'h20);
		tick(1);
		chk("irqSrc", 11, irqSrc);
		wr(8'hB9, 8'h01);
		tick(1);
		chk("irqSrc", 0, irqSrc);
		wr(8'hBB, 8'h20);
		tick(1);
		chk("irqSrc", 11, irqSrc);
		wr(8'hB8, 8'h01);
		tick(1);
		chk("irqSrc", 0, irqSrc);
		wr(8'hB8, 8'h00);
		wr(8'hB9, 8'h00);
		wr(8'hBA, 8'h00);
		wr(8'hBB, 8'h00);
		$display("test prio done");
	endtask : t_prio
	task t_nest;
		@(posedge core_clk) takeEn <= 1'b1;
		tick(4);
		chk("irqReq", 0, irqReq);
		@(posedge core_clk) takeEn <= 1'b0;
		wr(8'hBB, 8'h20);
		wr(8'hBA, 8'h20);
		tick(1);
		chk("irqSrc", 11, irqSrc);
		chk("irqReq", 1, irqReq);
		@(posedge core_clk) takeEn <= 1'b1;
		tick(3);
		@(posedge core_clk) begin takeEn <= 1'b0; srcFlag <= 12'h001; end
		tick(1);
		chk("irqReq", 0, irqReq);
		ret;
		chk("irqReq", 0, irqReq);
		ret;
		chk("irqReq", 1, irqReq);
		chk("irqSrc", 0, irqSrc);
		wr(8'hBA, 8'h00);
		wr(8'hBB, 8'h00);
		$display("test nest done");
	endtask : t_nest
	task t_wake;
		@(posedge core_clk) begin srcFlag <= 12'h000; pinWakeLevel <= 3'b100; end
		wr(8'hA8, 8'h00);
		wr(8'hA9, 8'h00);
		tick(3);
		chk("stopWake", 0, stopWake);
		wr(8'hA9, 8'h04);
		tick(1);
		chk("stopWake", 1, stopWake);
		@(posedge core_clk) begin pinWakeLevel <= 3'b000; port1Change <= 8'h01; srcFlag <= 12'h080; end
		wr(8'hA9, 8'h00);
		wr(8'h96, 8'h01);
		wr(8'hA8, 8'h80);
		tick(3);
		chk("stopWake", 1, stopWake);
		chk("irqReq", 0, irqReq);
		wr(8'hA9, 8'h02);
		tick(1);
		chk("irqReq", 1, irqReq);
		chk("irqSrc", 7, irqSrc);
		chk("stopWake", 1, stopWake);
		wr(8'h96, 8'h00);
		tick(1);
		chk("irqReq", 0, irqReq);
		chk("stopWake", 0, stopWake);
		@(posedge core_clk) pinWakeLevel <= 3'b010;
		wr(8'hA8, 8'h01);
		tick(3);
		chk("stopWake", 0, stopWake);
		wr(8'hA8, 8'h04);
		tick(1);
		chk("stopWake", 1, stopWake);
		$display("test wake done");
	endtask : t_wake
	task t_reset;
		wr(8'hA8, 8'h81);
		@(posedge core_clk) begin takeEn <= 1'b1; srcFlag <= 12'h001; end
		tick(3);
		chk("irqReq", 0, irqReq);
		@(posedge core_clk) begin takeEn <= 1'b0; resetn <= 1'b0; end
		tick(2);
		chk("irqReq", 0, irqReq);
		@(posedge core_clk) resetn <= 1'b1;
		rd(8'hA8, 8'h00);
		wr(8'hA8, 8'h81);
		tick(1);
		chk("irqReq", 1, irqReq);
		chk("irqSrc", 0, irqSrc);
		$display("test reset done");
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		t_regs;
		t_gate;
		t_prio;
		t_nest;
		t_wake;
		t_reset;
		report_and_stop;
	end
	// Whole run is well under a thousand cycles
	initial begin
		#20000;
		num_errors++;
		report_and_stop;
	end
endmodule : iepc_ctrl_tb
